//--- include/ebst_regs.vh
// ebst_regs.vh: register indices, field positions and reset values of the
// expansion bus strobe timing block; byte address is four times the index
`ifndef EBST_REGS_VH
`define EBST_REGS_VH

// register indices
`define EBST_IDX_QUAL 12'hc02
`define EBST_IDX_CS_RECOVERY 12'hc08
`define EBST_IDX_CS_WIDTH 12'hc09
`define EBST_IDX_CS_OFFSET 12'hc0a
`define EBST_IDX_RD_WIDTH 12'hc0b
`define EBST_IDX_RD_OFFSET 12'hc0c
`define EBST_IDX_WR_WIDTH 12'hc0d
`define EBST_IDX_WR_OFFSET 12'hc0e
`define EBST_IDX_ALE_WIDTH 12'hc0f
`define EBST_IDX_ALE_OFFSET 12'hc10
`define EBST_IDX_STATUS 12'hc11

// qualifier field layout: two bits per select, selects 4..0
`define EBST_QUAL_FIELD_W 2
`define EBST_QUAL_NUM_FIELDS 5
`define EBST_QUAL_IMPL_MASK 16'h03ff
`define EBST_QUAL_NONE 2'h0
`define EBST_QUAL_WRITE 2'h1
`define EBST_QUAL_READ 2'h2
`define EBST_QUAL_BOTH 2'h3

// status bits
`define EBST_STAT_IDLE 0
`define EBST_STAT_ACTIVE 1
`define EBST_STAT_RECOVER 2

// reset values
`define EBST_RST_QUAL 16'h0000
`define EBST_RST_TIMING 8'h00

`endif

//--- rtl/ebst_timing.v
// ebst_timing.v: expansion bus cycle timing, chip select qualification and
// its avalon-mm register slave
// assumes the cycle request port and the bus both run on sys_clk
//
// How it works
// R1: two qualifier bits per select, selects 4..0
// R2: 00 none, 01 write, 10 read, 11 both
// R3: single-type qualified select stays off otherwise
// R4: select may drop before its qualifying strobe; here all strobes are cut when the select ends
// R5: recovery lasts programmed value plus one
// R6: select width is programmed value plus one
// R7: select offset is programmed value plus one
// R8: read strobes width is value plus one
// R9: read strobes offset is value plus one
// R10: all timing counted in whole clock periods
// R11: software keeps select span covering all strobes
// R12: software bounds bus cycle length for pci
// R13: software enables select pin functions first
// R14: io target uses io strobes, else memory
// R15: write and latch pulses timed like reads
// R16: common start; recovery before next cycle
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ebst_regs.vh"

module ebst_timing #(
  parameter NUM_SEL = 8,
  parameter CNT_W = 10
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // avalon-mm register slave
  input wire [13:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // bus cycle request from the internal host
  input wire cyc_start,
  input wire cyc_write,
  input wire cyc_io,
  input wire [2:0] cyc_sel,
  output reg cyc_ready,
  output reg cyc_done,
  // expansion bus strobes, active high
  output reg [NUM_SEL-1:0] bus_chip_selects,
  output reg io_read_strobe,
  output reg io_write_strobe,
  output reg mem_read_strobe,
  output reg mem_write_strobe,
  output reg address_latch_pulse
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ACTIVE = 3'h2;
  localparam [2:0] ST_RECOVER = 3'h4;

  //////////////////////////////////////////////////////////////////////////
  // register file

  reg [15:0] cs_strobe_qualifier;
  reg [7:0] cs_recovery_time;
  reg [7:0] cs_pulse_width;
  reg [7:0] cs_assert_offset;
  reg [7:0] read_strobe_width;
  reg [7:0] read_strobe_offset;
  reg [7:0] write_strobe_width;
  reg [7:0] write_strobe_offset;
  reg [7:0] latch_pulse_width;
  reg [7:0] latch_pulse_offset;
  reg [2:0] state_reg;

  wire [11:0] reg_index = avs_address[13:2];
  wire bus_req = avs_read | avs_write;
  // a write lands only on the edge where the master sees waitrequest low
  wire wr_take = avs_write & ~avs_waitrequest;
  // only the five implemented fields may ever be set
  wire [15:0] qual_mask = `EBST_QUAL_IMPL_MASK;

  reg [31:0] rd_value;

  // read mux; unmapped indices read as zero
  always @* begin
    rd_value = 32'h0000_0000;
    case (reg_index)
      `EBST_IDX_QUAL: rd_value = {16'h0000, cs_strobe_qualifier};
      `EBST_IDX_CS_RECOVERY: rd_value = {24'h00_0000, cs_recovery_time};
      `EBST_IDX_CS_WIDTH: rd_value = {24'h00_0000, cs_pulse_width};
      `EBST_IDX_CS_OFFSET: rd_value = {24'h00_0000, cs_assert_offset};
      `EBST_IDX_RD_WIDTH: rd_value = {24'h00_0000, read_strobe_width};
      `EBST_IDX_RD_OFFSET: rd_value = {24'h00_0000, read_strobe_offset};
      `EBST_IDX_WR_WIDTH: rd_value = {24'h00_0000, write_strobe_width};
      `EBST_IDX_WR_OFFSET: rd_value = {24'h00_0000, write_strobe_offset};
      `EBST_IDX_ALE_WIDTH: rd_value = {24'h00_0000, latch_pulse_width};
      `EBST_IDX_ALE_OFFSET: rd_value = {24'h00_0000, latch_pulse_offset};
      `EBST_IDX_STATUS: rd_value = {29'h0000_0000, state_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // one wait cycle per access, then a single answer cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_value : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // register writes; unimplemented qualifier bits 15..10 stay zero
  always @(posedge sys_clk) begin
    if (rst) begin
      cs_strobe_qualifier <= `EBST_RST_QUAL;
      cs_recovery_time <= `EBST_RST_TIMING;
      cs_pulse_width <= `EBST_RST_TIMING;
      cs_assert_offset <= `EBST_RST_TIMING;
      read_strobe_width <= `EBST_RST_TIMING;
      read_strobe_offset <= `EBST_RST_TIMING;
      write_strobe_width <= `EBST_RST_TIMING;
      write_strobe_offset <= `EBST_RST_TIMING;
      latch_pulse_width <= `EBST_RST_TIMING;
      latch_pulse_offset <= `EBST_RST_TIMING;
    end else if (wr_take) begin
      if (reg_index == `EBST_IDX_QUAL) begin
        if (avs_byteenable[0])
          cs_strobe_qualifier[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1])
          cs_strobe_qualifier[15:8] <= avs_writedata[15:8] & qual_mask[15:8]; // R1
      end
      if (avs_byteenable[0]) begin
        case (reg_index)
          `EBST_IDX_CS_RECOVERY: cs_recovery_time <= avs_writedata[7:0];
          `EBST_IDX_CS_WIDTH: cs_pulse_width <= avs_writedata[7:0];
          `EBST_IDX_CS_OFFSET: cs_assert_offset <= avs_writedata[7:0];
          `EBST_IDX_RD_WIDTH: read_strobe_width <= avs_writedata[7:0];
          `EBST_IDX_RD_OFFSET: read_strobe_offset <= avs_writedata[7:0];
          `EBST_IDX_WR_WIDTH: write_strobe_width <= avs_writedata[7:0];
          `EBST_IDX_WR_OFFSET: write_strobe_offset <= avs_writedata[7:0];
          `EBST_IDX_ALE_WIDTH: latch_pulse_width <= avs_writedata[7:0];
          `EBST_IDX_ALE_OFFSET: latch_pulse_offset <= avs_writedata[7:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  // snapshot of the timing taken at cycle start, so software writes
  // during a cycle cannot tear its waveform
  reg [7:0] cs_off_reg;
  reg [7:0] cs_w_reg;
  reg [7:0] rec_reg;
  reg [7:0] rd_off_reg;
  reg [7:0] rd_w_reg;
  reg [7:0] wr_off_reg;
  reg [7:0] wr_w_reg;
  reg [7:0] ale_off_reg;
  reg [7:0] ale_w_reg;
  reg [9:0] qual_reg;
  reg write_reg;
  reg io_reg;
  reg [2:0] sel_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [7:0] rec_cnt_reg;

  // a start counts only while ready is shown, so the host knows what was taken
  wire start_take = cyc_start & cyc_ready & state_reg[0];

  // end of select pulse: offset plus one, then width plus one
  wire [CNT_W-1:0] cs_last = {{(CNT_W-8){1'b0}}, cs_off_reg} +
                             {{(CNT_W-8){1'b0}}, cs_w_reg} + {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      rec_cnt_reg <= 8'h00;
      cs_off_reg <= 8'h00;
      cs_w_reg <= 8'h00;
      rec_reg <= 8'h00;
      rd_off_reg <= 8'h00;
      rd_w_reg <= 8'h00;
      wr_off_reg <= 8'h00;
      wr_w_reg <= 8'h00;
      ale_off_reg <= 8'h00;
      ale_w_reg <= 8'h00;
      qual_reg <= 10'h000;
      write_reg <= 1'b0;
      io_reg <= 1'b0;
      sel_reg <= 3'h0;
      cyc_ready <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      cyc_done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cyc_ready <= ~start_take;
          if (start_take) begin
            // every offset counts from this common start edge
            state_reg <= ST_ACTIVE; // R16
            cnt_reg <= {CNT_W{1'b0}};
            cs_off_reg <= cs_assert_offset;
            cs_w_reg <= cs_pulse_width;
            rec_reg <= cs_recovery_time;
            rd_off_reg <= read_strobe_offset;
            rd_w_reg <= read_strobe_width;
            wr_off_reg <= write_strobe_offset;
            wr_w_reg <= write_strobe_width;
            ale_off_reg <= latch_pulse_offset;
            ale_w_reg <= latch_pulse_width;
            qual_reg <= cs_strobe_qualifier[9:0];
            write_reg <= cyc_write;
            io_reg <= cyc_io;
            sel_reg <= cyc_sel;
          end
        end
        ST_ACTIVE: begin
          cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // R10
          if (cnt_reg == cs_last) begin
            // select has just completed; strobes are cut here too
            state_reg <= ST_RECOVER; // R4
            rec_cnt_reg <= rec_reg;
          end
        end
        ST_RECOVER: begin
          // programmed value plus one cycles before the next start
          if (rec_cnt_reg == 8'h00) begin
            state_reg <= ST_IDLE; // R5
            cyc_ready <= 1'b1;
            cyc_done <= 1'b1;
          end else begin
            rec_cnt_reg <= rec_cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cyc_ready <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // strobe windows

  // high for count in [off+1, off+w+1], i.e. w+1 cycles after off+1
  function win;
    input [CNT_W-1:0] cnt;
    input [7:0] off;
    input [7:0] w;
    reg [CNT_W-1:0] first;
    reg [CNT_W-1:0] last;
    begin
      first = {{(CNT_W-8){1'b0}}, off} + {{(CNT_W-1){1'b0}}, 1'b1};
      last = first + {{(CNT_W-8){1'b0}}, w};
      win = (cnt >= first) && (cnt <= last);
    end
  endfunction

  // windows are evaluated on the next count so the outputs stay registered
  wire in_active = state_reg[1] && (cnt_reg != cs_last);
  wire [CNT_W-1:0] cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  wire cs_win = in_active && win(cnt_next, cs_off_reg, cs_w_reg); // R6 R7
  wire rd_win = in_active && !write_reg && win(cnt_next, rd_off_reg, rd_w_reg); // R8 R9
  wire wr_win = in_active && write_reg && win(cnt_next, wr_off_reg, wr_w_reg); // R15
  wire ale_win = in_active && win(cnt_next, ale_off_reg, ale_w_reg); // R15
  wire type_strobe = write_reg ? wr_win : rd_win;

  // per-select gating by its qualifier field
  wire [NUM_SEL-1:0] cs_next;
  genvar g;
  generate
    for (g = 0; g < NUM_SEL; g = g + 1) begin : gen_sel
      wire [1:0] field;
      wire type_ok;
      if (g < `EBST_QUAL_NUM_FIELDS) begin : gen_q
        assign field = qual_reg[g*2+1:g*2]; // R1
      end else begin : gen_nq
        // selects above 4 have no implemented field here
        assign field = `EBST_QUAL_NONE;
      end
      // write qualifier lives in bit 0, read qualifier in bit 1
      assign type_ok = write_reg ? field[0] : field[1]; // R2 R3
      assign cs_next[g] = cs_win && (sel_reg == g) &&
                          ((field == `EBST_QUAL_NONE) || (type_ok && type_strobe)); // R2
    end
  endgenerate

  // output flops; io target drives io strobes, memory target memory ones
  always @(posedge sys_clk) begin
    if (rst) begin
      bus_chip_selects <= {NUM_SEL{1'b0}};
      io_read_strobe <= 1'b0;
      io_write_strobe <= 1'b0;
      mem_read_strobe <= 1'b0;
      mem_write_strobe <= 1'b0;
      address_latch_pulse <= 1'b0;
    end else begin
      bus_chip_selects <= cs_next;
      io_read_strobe <= rd_win & io_reg; // R14
      io_write_strobe <= wr_win & io_reg; // R14
      mem_read_strobe <= rd_win & ~io_reg; // R8
      mem_write_strobe <= wr_win & ~io_reg; // R14
      address_latch_pulse <= ale_win;
    end
  end

endmodule

//--- tb/ebst_periph.sv
// ebst_periph.sv: bus peripheral that meters select and strobe pulses
// assumes active high pins sampled on sys_clk
`timescale 1ns/1ps
module ebst_periph (
  // clock
  input wire sys_clk,
  // pins seen by the peripheral
  input wire [7:0] bus_chip_selects,
  input wire strobe_any,
  // last pulse lengths
  output reg [8:0] cs_w,
  output reg [8:0] st_w
);
  reg [8:0] cs_cnt_reg = 9'h0;
  reg [8:0] st_cnt_reg = 9'h0;
  ////////////////////////////////
  // latched at the falling side so a truncated pulse still shows
  always @(posedge sys_clk) begin
    cs_cnt_reg <= (|bus_chip_selects) ? cs_cnt_reg + 9'h1 : 9'h0;
    st_cnt_reg <= strobe_any ? st_cnt_reg + 9'h1 : 9'h0;
    if (!(|bus_chip_selects) && cs_cnt_reg != 9'h0) cs_w <= cs_cnt_reg;
    if (!strobe_any && st_cnt_reg != 9'h0) st_w <= st_cnt_reg;
  end
endmodule

//--- tb/ebst_timing_properties.sv
// ebst_timing_properties.sv: port checks of the bus strobe timing block
// assumes one sys_clk domain with synchronous active high rst
`timescale 1ns/1ps
module ebst_timing_props #(
  parameter NUM_SEL = 8,
  parameter CNT_W = 10
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // cycle port
  input wire cyc_start,
  input wire cyc_ready,
  input wire cyc_done,
  // bus pins
  input wire [NUM_SEL-1:0] bus_chip_selects,
  input wire io_read_strobe,
  input wire io_write_strobe,
  input wire mem_read_strobe,
  input wire mem_write_strobe,
  input wire address_latch_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // decoded pin groups
  wire take = cyc_start && cyc_ready;
  wire rd_any = io_read_strobe || mem_read_strobe;
  wire wr_any = io_write_strobe || mem_write_strobe;
  wire io_any = io_read_strobe || io_write_strobe;
  wire mem_any = mem_read_strobe || mem_write_strobe;
  wire quiet = !(|bus_chip_selects) && !rd_any && !wr_any && !address_latch_pulse;
  ////////////////////////////////
  // register handshake, ready held low two cycles after a take, quiet and exclusive pins
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered in one cycle");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ready_held: assert property (take |=> !cyc_ready [*2])
    else $error("cycle ended too soon");
  a_start_quiet: assert property (take |=> quiet)
    else $error("pin asserted without offset");
  a_idle_quiet: assert property (cyc_ready |-> quiet)
    else $error("pin active while idle");
  a_one_select: assert property ($onehot0(bus_chip_selects))
    else $error("several selects at once");
  a_rw_apart: assert property (!(rd_any && wr_any))
    else $error("read and write strobes together");
  a_io_mem: assert property (!(io_any && mem_any))
    else $error("io and memory strobes together");
  a_select_recover: assert property ($fell(|bus_chip_selects) |-> !cyc_done && !cyc_ready)
    else $error("no recovery after select");
  a_done_pulse: assert property (cyc_done |-> cyc_ready ##1 !cyc_done)
    else $error("done not a single pulse");
  // main scenarios
  c_take: cover property (take);
  c_write: cover property ($rose(io_write_strobe));
  c_mem_read: cover property ($rose(mem_read_strobe));
endmodule
bind ebst_timing ebst_timing_props #(.NUM_SEL(NUM_SEL), .CNT_W(CNT_W)) i_props (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cyc_start(cyc_start), .cyc_ready(cyc_ready),
  .cyc_done(cyc_done), .bus_chip_selects(bus_chip_selects),
  .io_read_strobe(io_read_strobe), .io_write_strobe(io_write_strobe),
  .mem_read_strobe(mem_read_strobe), .mem_write_strobe(mem_write_strobe),
  .address_latch_pulse(address_latch_pulse));

//--- tb/ebst_timing_tb.sv
// ebst_timing_tb.sv: random and corner bus cycles against the timing block
// assumes the design header on the include path
`timescale 1ns/1ps
`include "ebst_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %0d expected %0d", $time, g, e); end end
module ebst_timing_tb;
  reg sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  reg cyc_start = 1'b0, cyc_write = 1'b0, cyc_io = 1'b0;
  reg [13:0] avs_address = 14'h0;
  reg [3:0] avs_byteenable = 4'hf, be = 4'hf;
  reg [31:0] avs_writedata = 32'h0, q;
  reg [2:0] cyc_sel = 3'h0;
  reg [9:0] qual;
  wire [31:0] avs_readdata;
  wire [7:0] bus_chip_selects;
  wire [8:0] cs_w, st_w;
  wire avs_waitrequest, cyc_ready, cyc_done, io_rd, io_wr, mem_rd, mem_wr, ale;
  int error_cnt = 0, tests_run = 0, o, w, r, ro, rw, ao, aw, efirst;
  ebst_timing i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cyc_start(cyc_start), .cyc_write(cyc_write),
    .cyc_io(cyc_io), .cyc_sel(cyc_sel), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
    .bus_chip_selects(bus_chip_selects), .io_read_strobe(io_rd),
    .io_write_strobe(io_wr), .mem_read_strobe(mem_rd), .mem_write_strobe(mem_wr),
    .address_latch_pulse(ale));
  // all eight select pins reach the peripheral, as if their pin functions were on
  ebst_periph i_periph (.sys_clk(sys_clk), .bus_chip_selects(bus_chip_selects),
    .strobe_any(io_rd | io_wr | mem_rd | mem_wr), .cs_w(cs_w), .st_w(st_w));
  ////////////////////////////////
  // one avalon access, held until waitrequest is seen low
  task bus(input bit wr, input [11:0] idx, input [31:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function int mn(input int a, input int b);
    return a < b ? a : b;
  endfunction
  // strobes kept inside the select window, so a qualified select is the strobe
  task setcfg(input int ov, input int wv, input int rv, input [9:0] qv);
    o = ov;
    w = wv;
    r = rv;
    qual = qv;
    ro = o + $urandom % (mn(w, 255 - o) + 1);
    rw = $urandom % (mn(o + w - ro, 255) + 1);
    ao = $urandom % (o + 1);
    aw = $urandom % (mn(o + w - ao, 255) + 1);
    bus(1, `EBST_IDX_CS_RECOVERY, r);
    bus(1, `EBST_IDX_CS_WIDTH, w);
    bus(1, `EBST_IDX_CS_OFFSET, o);
    bus(1, `EBST_IDX_RD_WIDTH, rw);
    bus(1, `EBST_IDX_RD_OFFSET, ro);
    bus(1, `EBST_IDX_WR_WIDTH, rw);
    bus(1, `EBST_IDX_WR_OFFSET, ro);
    bus(1, `EBST_IDX_ALE_WIDTH, aw);
    bus(1, `EBST_IDX_ALE_OFFSET, ao);
    bus(1, `EBST_IDX_QUAL, {16'h0, 6'h3f, qv});
    bus(0, `EBST_IDX_QUAL, 0);
    `CHK(q, {22'h0, qv})
    bus(0, `EBST_IDX_CS_OFFSET, 0);
    `CHK(q, o)
    bus(0, `EBST_IDX_ALE_OFFSET, 0);
    `CHK(q, ao)
  endtask
  // expected select cycles from the field of the chosen select
  function int exp_cs(input bit wr, input [2:0] s);
    reg [1:0] f;
    f = (s < 5) ? qual[s*2 +: 2] : 2'h0;
    efirst = (f == 2'h0) ? o + 2 : ro + 2;
    if (f == 2'h0) return w + 1;
    if (f == 2'h3 || f == {!wr, wr}) return rw + 1;
    return 0;
  endfunction
  // one bus cycle, measured edge by edge from the taking edge
  task run(input bit wr, input bit io, input [2:0] s);
    int n, first, sfirst, hits, bad, ec, ahits, afirst;
    @(posedge sys_clk);
    cyc_start <= 1'b1;
    cyc_write <= wr;
    cyc_io <= io;
    cyc_sel <= s;
    do @(posedge sys_clk); while (cyc_ready !== 1'b1);
    cyc_start <= 1'b0;
    {n, first, sfirst, hits, bad, ahits, afirst} = 0;
    ec = exp_cs(wr, s);
    do begin
      @(posedge sys_clk);
      n++;
      if (bus_chip_selects[s] === 1'b1 && first == 0) first = n;
      hits += bus_chip_selects[s];
      ahits += ale;
      if (ale === 1'b1 && afirst == 0) afirst = n;
      if ((wr ? (io ? io_wr : mem_wr) : (io ? io_rd : mem_rd)) && sfirst == 0) sfirst = n;
      bad += (wr ? io_rd | mem_rd : io_wr | mem_wr) | (io ? mem_rd | mem_wr : io_rd | io_wr);
      bad += |(bus_chip_selects & ~(8'h1 << s));
    end while (cyc_done !== 1'b1 && n < 2000);
    `CHK(n, o + w + r + 4)
    `CHK(hits, ec)
    `CHK(bad, 0)
    `CHK(sfirst, ro + 2)
    `CHK(st_w, rw + 1)
    `CHK(ahits, aw + 1)
    `CHK(afirst, ao + 2)
    if (ec != 0) begin
      `CHK(first, efirst)
      `CHK(cs_w, ec)
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////
  // clock, watchdog and main sequence
  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    #400000;
    error_cnt++;
    results;
  end
  initial begin
    q = $urandom(52);
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // idle shows in bit 0 of the status word
    bus(0, `EBST_IDX_STATUS, 0);
    `CHK(q, 32'h1)
    bus(0, `EBST_IDX_CS_WIDTH, 0);
    `CHK(q, 32'h0)
    be = 4'h2;
    bus(1, `EBST_IDX_CS_WIDTH, 32'h55);
    be = 4'hf;
    bus(1, 12'hc07, 32'h5a);
    bus(0, `EBST_IDX_CS_WIDTH, 0);
    `CHK(q, 32'h0)
    bus(0, 12'hc07, 0);
    `CHK(q, 32'h0)
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      setcfg(1, 3, 0, {8'h0, c[2:1]});
      run(c[0], c[1], 3'h0);
    end
    setcfg(0, 0, 0, 10'h0);
    run(1'b0, 1'b0, 3'h7);
    // longest cycle is under 800 clocks, well inside the 10 us write budget
    setcfg(255, 255, 255, 10'h3ff);
    run(1'b0, 1'b1, 3'h4);
    $display("test corners done");
    repeat (12) begin
      setcfg($urandom % 4, $urandom % 6, $urandom % 4, $urandom);
      run($urandom, $urandom, $urandom);
      run($urandom, $urandom, $urandom);
    end
    $display("test random done");
    results;
  end
endmodule
